// ### msc_pin_ctrl.sv
// Purpose: Pad control for management data, interrupt, frame-start, lamp and GPIO pins.
// Assumes: Pad inputs are asynchronous; event and source inputs share clk_sys_in.
// Notes: Output enables are active low; every output comes from a flip-flop.
`include "msc_defines.svh"

// How it works
// - Management pad style from buffer bit, overrides.
// - Interrupt pad push-pull or open-drain, open-drain default.
// - Interrupt polarity invert bit, active low default.
// - Chip reset active low; straps sampled at release.
// - Lamp active level from its latched strap.
// - Frame-start pulse per indicator for ports 3-0.
// - Select register picks port, direction; else shared.
// - Twenty-four GPIOs with buffer and alternate selection.
module msc_pin_ctrl (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Avalon-MM slave.
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    // Chip reset pin, active low.
    input wire logic chip_rst_n_in,
    // Management data pad and its core side.
    input wire logic mdio_core_data_in,
    input wire logic mdio_core_drive_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n_out,
    output logic mdio_rx_out,
    // Interrupt pad and the core's pending sources.
    input wire logic [3:0] int_src_in,
    output logic int_pad_out,
    output logic int_pad_oe_n_out,
    // Frame-start events and indicator pins.
    input wire logic [3:0] sof_rx_in,
    input wire logic [3:0] sof_tx_in,
    input wire logic [3:0] sof_shared_in,
    output logic [3:0] sof_out,
    // Lamp pads and their on requests.
    input wire logic [3:0] lamp_a_on_in,
    input wire logic [3:0] lamp_b_on_in,
    input wire logic [3:0] lamp_a_port_in,
    input wire logic [3:0] lamp_b_port_in,
    output logic [3:0] lamp_a_port_out,
    output logic [3:0] lamp_b_port_out,
    output logic [3:0] lamp_a_oe_n_out,
    output logic [3:0] lamp_b_oe_n_out,
    // General-purpose pads and alternate sources.
    input wire logic [23:0] gpio_in,
    input wire logic [23:0] gpio_alt_a_in,
    input wire logic [23:0] gpio_alt_b_in,
    input wire logic [23:0] gpio_alt_c_in,
    output logic [23:0] gpio_out,
    output logic [23:0] gpio_oe_n_out
);

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic sof_pick(input msc_pkg::msc_sof_sel_t sel,
                                      input logic [3:0] rx,
                                      input logic [3:0] tx);
        return sel.tx ? tx[sel.port] : rx[sel.port];
    endfunction

    msc_pkg::msc_pins_t pins_raw;
    msc_pkg::msc_pins_t pins_s;
    msc_pkg::msc_out_ctrl_t out_ctrl_q;
    msc_pkg::msc_sof_sel_t [3:0] sof_sel_q;
    msc_pkg::msc_straps_t straps_q;
    logic [3:0] test_ovr_q;
    logic [`MSC_IRQ_W-1:0] irq_stat_q;
    logic [`MSC_IRQ_W-1:0] irq_stat_d;
    logic [`MSC_IRQ_W-1:0] irq_mask_q;
    logic [`MSC_IRQ_W-1:0] irq_set;
    logic [23:0] gpio_dir_q;
    logic [23:0] gpio_od_q;
    logic [47:0] gpio_alt_q;
    logic [23:0] gpio_dout_q;
    logic chip_rst_n_d1_q;
    logic strap_edge;
    logic bus_req;
    logic bus_ack;
    logic [31:0] rd_mux;
    logic [31:0] wr_old;
    logic [31:0] wr_new;
    logic int_pending;
    logic int_level;
    logic [3:0] sof_hit;
    logic [23:0] gpio_val;

    // All pad inputs pass two flops before use.
    assign pins_raw = {gpio_in, mdio_in, lamp_b_port_in, lamp_a_port_in, chip_rst_n_in};

    msc_sync #(
        .W(`MSC_SYNC_W)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // Bus handshake: one wait cycle, then acknowledge for one cycle.
    assign bus_req = avs_read_in | avs_write_in;
    assign bus_ack = bus_req & ~avs_waitrequest_out;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if (bus_req && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address_in)
            `MSC_OFS_OUT_CTRL: rd_mux = {29'h0, out_ctrl_q};
            `MSC_OFS_TEST_OVR: rd_mux = {28'h0, test_ovr_q};
            `MSC_OFS_SOF_SEL: rd_mux = {16'h0, sof_sel_q};
            `MSC_OFS_STRAPS: rd_mux = {23'h0, straps_q};
            `MSC_OFS_IRQ_STAT: rd_mux = {27'h0, irq_stat_q};
            `MSC_OFS_IRQ_MASK: rd_mux = {27'h0, irq_mask_q};
            `MSC_OFS_GPIO_DIR: rd_mux = {8'h0, gpio_dir_q};
            `MSC_OFS_GPIO_OD: rd_mux = {8'h0, gpio_od_q};
            `MSC_OFS_GPIO_ALT_LO: rd_mux = gpio_alt_q[31:0];
            `MSC_OFS_GPIO_ALT_HI: rd_mux = {16'h0, gpio_alt_q[47:32]};
            `MSC_OFS_GPIO_DOUT: rd_mux = {8'h0, gpio_dout_q};
            `MSC_OFS_GPIO_DIN: rd_mux = {8'h0, pins_s.gpio};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && avs_waitrequest_out) begin
            avs_readdata_out <= rd_mux;
        end
    end

    // Writes land at the acknowledge edge, merged per byte lane.
    assign wr_old = rd_mux;
    assign wr_new = be_merge(wr_old, avs_writedata_in, avs_byteenable_in);

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            out_ctrl_q <= `MSC_OUT_CTRL_RST;
            test_ovr_q <= 4'h0;
            irq_mask_q <= '0;
        end else if (bus_ack && avs_write_in) begin
            case (avs_address_in)
                `MSC_OFS_OUT_CTRL: out_ctrl_q <= wr_new[2:0];
                `MSC_OFS_TEST_OVR: test_ovr_q <= wr_new[3:0];
                `MSC_OFS_IRQ_MASK: irq_mask_q <= wr_new[`MSC_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            sof_sel_q <= `MSC_SOF_SEL_RST;
        end else if (bus_ack && avs_write_in && avs_address_in == `MSC_OFS_SOF_SEL) begin
            sof_sel_q <= wr_new[15:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            gpio_dir_q <= 24'h00_0000;
            gpio_od_q <= 24'h00_0000;
            gpio_alt_q <= 48'h0000_0000_0000;
            gpio_dout_q <= 24'h00_0000;
        end else if (bus_ack && avs_write_in) begin
            case (avs_address_in)
                `MSC_OFS_GPIO_DIR: gpio_dir_q <= wr_new[23:0];
                `MSC_OFS_GPIO_OD: gpio_od_q <= wr_new[23:0];
                `MSC_OFS_GPIO_ALT_LO: gpio_alt_q[31:0] <= wr_new;
                `MSC_OFS_GPIO_ALT_HI: gpio_alt_q[47:32] <= wr_new[15:0];
                `MSC_OFS_GPIO_DOUT: gpio_dout_q <= wr_new[23:0];
                default: ;
            endcase
        end
    end

    // Chip reset release and strap capture.
    assign strap_edge = pins_s.chip_rst_n & ~chip_rst_n_d1_q;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            chip_rst_n_d1_q <= 1'b0;
        end else begin
            chip_rst_n_d1_q <= pins_s.chip_rst_n;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            straps_q <= '0;
        end else if (!pins_s.chip_rst_n) begin
            straps_q.valid <= 1'b0;
        end else if (strap_edge) begin
            straps_q.lamp_a <= pins_s.lamp_a;
            straps_q.lamp_b <= pins_s.lamp_b;
            straps_q.valid <= 1'b1;
        end
    end
    // Outside the release edge the strap values are left alone.

    // Sticky events; a read of the status register clears them, a new event wins.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sof_hit[i] = sof_sel_q[i].en & sof_pick(sof_sel_q[i], sof_rx_in, sof_tx_in);
        end
    end

    assign irq_set = {strap_edge, sof_hit};
    // Only the bits that the read returned are cleared, so a late event is kept.
    assign irq_stat_d = (bus_ack && avs_read_in && avs_address_in == `MSC_OFS_IRQ_STAT)
                        ? ((irq_stat_q & ~avs_readdata_out[`MSC_IRQ_W-1:0]) | irq_set)
                        : (irq_stat_q | irq_set);

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            irq_stat_q <= '0;
            irq_out <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_out <= |(irq_stat_d & irq_mask_q);
        end
    end

    // Frame-start indicators.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            sof_out <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                sof_out[i] <= sof_sel_q[i].en ? sof_hit[i] : sof_shared_in[i];
            end
        end
    end

    // Interrupt pad.
    assign int_pending = |int_src_in | irq_out;
    assign int_level = int_pending ~^ out_ctrl_q.int_inv;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            int_pad_out <= 1'b0;
            int_pad_oe_n_out <= 1'b1;
        end else if (out_ctrl_q.int_pp) begin
            int_pad_out <= int_level;
            int_pad_oe_n_out <= 1'b0;
        end else begin
            int_pad_out <= 1'b0;
            int_pad_oe_n_out <= int_level;
        end
    end

    // Management data pad.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            mdio_out <= 1'b0;
            mdio_oe_n_out <= 1'b1;
            mdio_rx_out <= 1'b0;
        end else begin
            mdio_rx_out <= pins_s.mdio;
            if (out_ctrl_q.mdio_pp && test_ovr_q == 4'h0) begin
                mdio_out <= mdio_core_data_in;
                mdio_oe_n_out <= ~mdio_core_drive_in;
            end else begin
                mdio_out <= 1'b0;
                mdio_oe_n_out <= ~(mdio_core_drive_in & ~mdio_core_data_in);
            end
        end
    end

    // Lamp pads: released while chip reset holds so straps can be read.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            lamp_a_port_out <= 4'h0;
            lamp_b_port_out <= 4'h0;
            lamp_a_oe_n_out <= 4'hf;
            lamp_b_oe_n_out <= 4'hf;
        end else begin
            lamp_a_port_out <= lamp_a_on_in ^ straps_q.lamp_a;
            lamp_b_port_out <= lamp_b_on_in ^ straps_q.lamp_b;
            lamp_a_oe_n_out <= {4{~straps_q.valid}};
            lamp_b_oe_n_out <= {4{~straps_q.valid}};
        end
    end

    // General-purpose pad values by alternate selection.
    always_comb begin
        for (int i = 0; i < `MSC_NUM_GPIO; i++) begin
            case (gpio_alt_q[i*2 +: 2])
                `MSC_ALT_GPIO: gpio_val[i] = gpio_dout_q[i];
                `MSC_ALT_FUNC_A: gpio_val[i] = gpio_alt_a_in[i];
                `MSC_ALT_FUNC_B: gpio_val[i] = gpio_alt_b_in[i];
                `MSC_ALT_FUNC_C: gpio_val[i] = gpio_alt_c_in[i];
                default: gpio_val[i] = gpio_dout_q[i];
            endcase
        end
    end

    // General-purpose pads.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            gpio_out <= 24'h00_0000;
            gpio_oe_n_out <= 24'hff_ffff;
        end else begin
            for (int i = 0; i < `MSC_NUM_GPIO; i++) begin
                if (gpio_od_q[i]) begin
                    gpio_out[i] <= 1'b0;
                    gpio_oe_n_out[i] <= ~(gpio_dir_q[i] & ~gpio_val[i]);
                end else begin
                    gpio_out[i] <= gpio_val[i];
                    gpio_oe_n_out[i] <= ~gpio_dir_q[i];
                end
            end
        end
    end

endmodule

// ### msc_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the pin control block.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

`define MSC_ADDR_W 8
`define MSC_NUM_PORTS 4
`define MSC_NUM_GPIO 24

`define MSC_OFS_OUT_CTRL 8'h00
`define MSC_OFS_TEST_OVR 8'h04
`define MSC_OFS_SOF_SEL 8'h08
`define MSC_OFS_STRAPS 8'h0c
`define MSC_OFS_IRQ_STAT 8'h10
`define MSC_OFS_IRQ_MASK 8'h14
`define MSC_OFS_GPIO_DIR 8'h18
`define MSC_OFS_GPIO_OD 8'h1c
`define MSC_OFS_GPIO_ALT_LO 8'h20
`define MSC_OFS_GPIO_ALT_HI 8'h24
`define MSC_OFS_GPIO_DOUT 8'h28
`define MSC_OFS_GPIO_DIN 8'h2c

`define MSC_BIT_MDIO_PP 0
`define MSC_BIT_INT_PP 1
`define MSC_BIT_INT_INV 2
`define MSC_OUT_CTRL_RST 3'h0

`define MSC_SOF_FIELD_W 4
`define MSC_SOF_SEL_RST 16'h0000
`define MSC_BIT_STRAP_VALID 8
`define MSC_BIT_IRQ_STRAP 4
`define MSC_IRQ_W 5
`define MSC_ALT_LO_PINS 16

`define MSC_ALT_GPIO 2'h0
`define MSC_ALT_FUNC_A 2'h1
`define MSC_ALT_FUNC_B 2'h2
`define MSC_ALT_FUNC_C 2'h3

`define MSC_SYNC_W 34

`endif

// ### msc_pkg.sv
// Purpose: Types shared by the pin control block.
// Assumes: Constants come from msc_defines.svh.
// Notes: None.
package msc_pkg;

    typedef struct packed {
        logic int_inv;
        logic int_pp;
        logic mdio_pp;
    } msc_out_ctrl_t;

    typedef struct packed {
        logic en;
        logic tx;
        logic [1:0] port;
    } msc_sof_sel_t;

    typedef struct packed {
        logic [23:0] gpio;
        logic mdio;
        logic [3:0] lamp_b;
        logic [3:0] lamp_a;
        logic chip_rst_n;
    } msc_pins_t;

    typedef struct packed {
        logic valid;
        logic [3:0] lamp_b;
        logic [3:0] lamp_a;
    } msc_straps_t;

endpackage

// ### msc_sync.sv
// Purpose: Two-flop synchroniser for pad inputs.
// Assumes: Inputs are asynchronous to clk_sys_in.
// Notes: The first stage feeds only the second.
module msc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Data.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ### msc_far_end.sv
// Purpose: Board side of the pin control block: strap resistors, pull-ups and reset source.
// Assumes: The reset level comes from the bench.
// Notes: A released pad shows its resistor level, never the last driven value.
module msc_far_end (
    // Strap resistor levels and reset source.
    input wire logic [3:0] strap_a_in,
    input wire logic [3:0] strap_b_in,
    input wire logic chip_rst_n_in,
    // Pads as the device drives them.
    input wire logic [3:0] lamp_a_in,
    input wire logic [3:0] lamp_a_oe_n_in,
    input wire logic [3:0] lamp_b_in,
    input wire logic [3:0] lamp_b_oe_n_in,
    input wire logic mdio_in,
    input wire logic mdio_oe_n_in,
    input wire logic [23:0] gpio_in,
    input wire logic [23:0] gpio_oe_n_in,
    // Resolved pad levels.
    output msc_pkg::msc_pins_t pins_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        pins_out.chip_rst_n = chip_rst_n_in;
        pins_out.lamp_a = (lamp_a_oe_n_in & strap_a_in) | (~lamp_a_oe_n_in & lamp_a_in);
        pins_out.lamp_b = (lamp_b_oe_n_in & strap_b_in) | (~lamp_b_oe_n_in & lamp_b_in);
        pins_out.mdio = mdio_oe_n_in | mdio_in;
        pins_out.gpio = gpio_oe_n_in | gpio_in;
    end
endmodule

// ### msc_pin_ctrl_chk.sv
// Purpose: Concurrent checks at the ports of the pin control block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every instance of the block.
module msc_pin_ctrl_chk (
    // Clock, reset and bus.
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // Pads and their sources.
    input wire logic chip_rst_n_in,
    input wire logic mdio_core_data_in,
    input wire logic mdio_out,
    input wire logic int_pad_out,
    input wire logic int_pad_oe_n_out,
    input wire logic [3:0] sof_rx_in,
    input wire logic [3:0] sof_tx_in,
    input wire logic [3:0] sof_shared_in,
    input wire logic [3:0] sof_out,
    input wire logic [3:0] lamp_a_on_in,
    input wire logic [3:0] lamp_a_port_out,
    input wire logic [3:0] lamp_a_oe_n_out,
    input wire logic [3:0] lamp_b_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_chip_low;
        !chip_rst_n_in [*5];
    endsequence
    sequence s_chip_up;
        chip_rst_n_in [*8];
    endsequence
    a_wait_one: assert property (s_req |=> !avs_waitrequest_out)
        else $error("waitrequest did not drop after one cycle");
    a_wait_back: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_int_od_low: assert property (int_pad_oe_n_out |-> !int_pad_out)
        else $error("released interrupt pad drives high");
    a_mdio_data: assert property (mdio_out |-> $past(mdio_core_data_in))
        else $error("management pad high without data");
    a_sof_cause: assert property (sof_out != 4'h0 |->
        $past(sof_rx_in | sof_tx_in | sof_shared_in) != 4'h0)
        else $error("frame-start pulse without cause");
    a_lamp_release: assert property (s_chip_low |->
        lamp_a_oe_n_out == 4'hf && lamp_b_oe_n_out == 4'hf)
        else $error("lamp pads driven during chip reset");
    a_lamp_hold: assert property (s_chip_up |-> $stable(lamp_a_oe_n_out))
        else $error("lamp enable moved while chip reset high");
    a_lamp_follow: assert property (s_chip_up |-> (lamp_a_port_out ^ $past(lamp_a_port_out))
        == ($past(lamp_a_on_in) ^ $past(lamp_a_on_in, 2)))
        else $error("lamp pad does not follow its request");
endmodule
bind msc_pin_ctrl msc_pin_ctrl_chk u_chk (.clk_sys_in, .sys_rst_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .chip_rst_n_in, .mdio_core_data_in, .mdio_out, .int_pad_out,
    .int_pad_oe_n_out, .sof_rx_in, .sof_tx_in, .sof_shared_in, .sof_out, .lamp_a_on_in,
    .lamp_a_port_out, .lamp_a_oe_n_out, .lamp_b_oe_n_out);

// ### msc_pin_ctrl_tb.sv
// Purpose: Self-checking bench for the pin control block.
// Assumes: Registers as in msc_defines.svh, one wait cycle per access.
// Notes: Expected values come from the bench's own model.
`include "msc_defines.svh"
module msc_pin_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, chip_rst_n = 1'b0;
    logic avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out, irq_out;
    logic [7:0] avs_address_in = 8'h00;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, r;
    logic mdio_core_data_in = 1'b0, mdio_core_drive_in = 1'b0, mdio_out, mdio_oe_n_out;
    logic int_pad_out, int_pad_oe_n_out, lvl, pp, mdio_rx_out;
    logic [3:0] int_src_in = 4'h0, sof_rx_in = 4'h0, sof_tx_in = 4'h0, sof_shared_in = 4'h0;
    logic [3:0] lamp_a_on_in = 4'h0, lamp_b_on_in = 4'h0, strap_a = 4'h5, strap_b = 4'h3;
    logic [3:0] sof_out, lamp_a_port_out, lamp_b_port_out, lamp_a_oe_n_out, lamp_b_oe_n_out;
    logic [23:0] gpio_alt_a_in = 24'h0, gpio_alt_b_in = 24'h0, gpio_alt_c_in = 24'h0;
    logic [23:0] gpio_out, gpio_oe_n_out, eo, eoe;
    logic [31:0] g[8];
    logic [7:0] old;
    msc_pkg::msc_pins_t pins;
    int seed = 46, total_checks = 0, bad_count = 0, i, c, k, sel;

    msc_far_end FE (.strap_a_in(strap_a), .strap_b_in(strap_b), .chip_rst_n_in(chip_rst_n),
        .lamp_a_in(lamp_a_port_out), .lamp_a_oe_n_in(lamp_a_oe_n_out),
        .lamp_b_in(lamp_b_port_out), .lamp_b_oe_n_in(lamp_b_oe_n_out), .mdio_in(mdio_out),
        .mdio_oe_n_in(mdio_oe_n_out), .gpio_in(gpio_out), .gpio_oe_n_in(gpio_oe_n_out),
        .pins_out(pins));
    msc_pin_ctrl DUT (.clk_sys_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
        .irq_out, .chip_rst_n_in(pins.chip_rst_n), .mdio_core_data_in, .mdio_core_drive_in,
        .mdio_in(pins.mdio), .mdio_out, .mdio_oe_n_out, .mdio_rx_out, .int_src_in,
        .int_pad_out, .int_pad_oe_n_out, .sof_rx_in, .sof_tx_in, .sof_shared_in, .sof_out,
        .lamp_a_on_in, .lamp_b_on_in, .lamp_a_port_in(pins.lamp_a), .lamp_b_port_in(pins.lamp_b),
        .lamp_a_port_out, .lamp_b_port_out, .lamp_a_oe_n_out, .lamp_b_oe_n_out,
        .gpio_in(pins.gpio), .gpio_alt_a_in, .gpio_alt_b_in, .gpio_alt_c_in, .gpio_out,
        .gpio_oe_n_out);

    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !w;
        avs_write_in <= w;
        do begin
            @(posedge clk_sys_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
    initial begin
        tick(12);
        sys_rst_in <= 1'b0;
        tick(6);
        chip_rst_n <= 1'b1;
        tick(8);
        rd("straps", `MSC_OFS_STRAPS, {23'h0, 1'b1, strap_b, strap_a});
        rd("irq_stat", `MSC_OFS_IRQ_STAT, 32'h10);
        rd("out_ctrl", `MSC_OFS_OUT_CTRL, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        $display("registers done");
        for (c = 0; c < 8; c++) begin
            wr(`MSC_OFS_OUT_CTRL, 32'(c[2:1]) << 1);
            r = $random(seed);
            int_src_in <= c[0] ? (r[3:0] | 4'h1) : 4'h0;
            tick(2);
            lvl = c[0] ~^ c[2];
            chk("int_out", int_pad_out, c[1] ? lvl : 1'b0);
            chk("int_oe_n", int_pad_oe_n_out, c[1] ? 1'b0 : lvl);
        end
        int_src_in <= 4'h0;
        $display("interrupt pad done");
        wr(`MSC_OFS_IRQ_MASK, 32'h1f);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(`MSC_OFS_SOF_SEL, 32'({1'b1, r[2:0]}) << (4 * i));
            sof_tx_in <= r[2] ? 4'h1 << r[1:0] : 4'hf;
            sof_rx_in <= r[2] ? 4'hf : 4'h1 << r[1:0];
            tick(1);
            sof_tx_in <= 4'h0;
            sof_rx_in <= 4'h0;
            tick(1);
            chk("sof_out", sof_out, 4'h1 << i);
            chk("irq", irq_out, 1'b1);
            rd("sof_stat", `MSC_OFS_IRQ_STAT, 32'h1 << i);
            chk("irq_clr", irq_out, 1'b0);
        end
        wr(`MSC_OFS_SOF_SEL, 32'h0);
        r = $random(seed);
        sof_shared_in <= r[3:0];
        tick(2);
        chk("sof_shared", sof_out, r[3:0]);
        rd("no_stat", `MSC_OFS_IRQ_STAT, 32'h0);
        sof_shared_in <= 4'h0;
        $display("frame start done");
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            wr(`MSC_OFS_OUT_CTRL, 32'(i[0]));
            wr(`MSC_OFS_TEST_OVR, i[1] ? 32'h1 << r[5:4] : 32'h0);
            mdio_core_data_in <= i[2];
            mdio_core_drive_in <= i[3];
            tick(2);
            pp = i[0] && !i[1];
            chk("mdio_out", mdio_out, pp ? i[2] : 1'b0);
            chk("mdio_oe_n", mdio_oe_n_out, pp ? !i[3] : !(i[3] && !i[2]));
            tick(3);
            chk("mdio_rx", mdio_rx_out, !i[3] || i[2]);
        end
        $display("management pad done");
        r = $random(seed);
        lamp_a_on_in <= r[3:0];
        lamp_b_on_in <= r[7:4];
        tick(2);
        chk("lamp_a", lamp_a_port_out, r[3:0] ^ strap_a);
        chk("lamp_b", lamp_b_port_out, r[7:4] ^ strap_b);
        old = {strap_b, strap_a};
        strap_a <= ~strap_a;
        strap_b <= r[11:8];
        tick(4);
        rd("straps_hold", `MSC_OFS_STRAPS, {23'h0, 1'b1, old});
        chip_rst_n <= 1'b0;
        tick(6);
        chk("lamp_rel", {lamp_a_oe_n_out, lamp_b_oe_n_out}, 8'hff);
        rd("straps_low", `MSC_OFS_STRAPS, {23'h0, 1'b0, old});
        chip_rst_n <= 1'b1;
        tick(8);
        rd("straps_new", `MSC_OFS_STRAPS, {23'h0, 1'b1, strap_b, strap_a});
        chk("lamp_new", lamp_a_port_out, r[3:0] ^ strap_a);
        $display("lamps done");
        for (k = 0; k < 8; k++) g[k] = $random(seed);
        for (k = 0; k < 5; k++) wr(`MSC_OFS_GPIO_DIR + 8'(4 * k), g[k]);
        gpio_alt_a_in <= g[5][23:0];
        gpio_alt_b_in <= g[6][23:0];
        gpio_alt_c_in <= g[7][23:0];
        tick(2);
        for (k = 0; k < 24; k++) begin
            sel = (k < 16 ? g[2] >> (2 * k) : g[3] >> (2 * k - 32)) & 3;
            lvl = g[sel == 0 ? 4 : 4 + sel][k];
            eo[k] = g[1][k] ? 1'b0 : lvl;
            eoe[k] = g[1][k] ? !(g[0][k] && !lvl) : !g[0][k];
        end
        chk("gpio_out", gpio_out, eo);
        chk("gpio_oe_n", gpio_oe_n_out, eoe);
        tick(4);
        rd("gpio_din", `MSC_OFS_GPIO_DIN, {8'h0, eoe | eo});
        avs_byteenable_in <= 4'h2;
        wr(`MSC_OFS_GPIO_DIR, ~g[0]);
        avs_byteenable_in <= 4'hf;
        rd("gpio_dir", `MSC_OFS_GPIO_DIR, {8'h0, g[0][23:16], ~g[0][15:8], g[0][7:0]});
        $display("gpio done");
        test_done();
    end
endmodule
